/* File: isr_pkg.sv */
/*
 Package for the interrupt source routing block: register offsets,
 field positions, reset values and routing codes.
 Assumes a byte-wide register port with an 8-bit address.
*/
`default_nettype none
package isr_pkg;
   localparam int ISR_ADDR_W = 8;
   localparam int ISR_DATA_W = 8;
   localparam int ISR_ROUTE_W = 3;
   localparam int ISR_NUM_OUT = 4;
   localparam int ISR_NUM_SRC = 7;
   // Register offsets
   localparam logic [7:0] ISR_OFS_SECOND_CLOCK_FAULT = 8'h6E;
   localparam logic [7:0] ISR_OFS_CONV_DONE_CLK_LOST = 8'h6F;
   localparam logic [7:0] ISR_OFS_PROG_ONE_TWO = 8'h70;
   localparam logic [7:0] ISR_OFS_PROG_THREE_FOUR = 8'h71;
   // Field positions: high field at bits 6..4, low field at bits 2..0
   localparam int ISR_HI_LSB = 4;
   localparam int ISR_LO_LSB = 0;
   localparam int ISR_RSV_HI_BIT = 7;
   localparam int ISR_RSV_LO_BIT = 3;
   localparam logic [7:0] ISR_REG_RESET = 8'h00;
   // Routing codes
   localparam logic [2:0] ISR_ROUTE_NONE = 3'h0;
   localparam logic [2:0] ISR_ROUTE_FIRST = 3'h1;
   localparam logic [2:0] ISR_ROUTE_LAST = 3'h4;
endpackage
`default_nettype wire

/* File: isr_route_decode.sv */
/*
 One routing field decoder: turns a 3-bit route code into a one-hot
 request vector over the interrupt outputs.
 Assumes the source input is already on the register clock.
*/
`timescale 1ns/1ps
`default_nettype none
module isr_route_decode
   import isr_pkg::*;
(
   input wire logic [ISR_ROUTE_W-1:0] route_i,
   input wire logic src_i,
   output logic [ISR_NUM_OUT-1:0] req_o
);
   // Code 0 and reserved codes 5..7 give no request
   always_comb
   begin
      req_o = '0;
      for (int k = 0; k < ISR_NUM_OUT; k++)
      begin
         if (src_i && route_i == ISR_ROUTE_FIRST + 3'(k))
         begin
            req_o[k] = 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: isr_top.sv */
/*
 Interrupt source routing matrix: four byte-wide routing registers and
 the OR-combination of routed sources onto four interrupt lines.
 Assumes a same-clock register port (one-cycle write strobe, read data
 registered) and event sources already synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Route code 0 drops the source; codes 1 to 4 pick output one to four.
// - Second clock fault route in bits 2..0, bit 3 reserved read/write, reset zero.
// - Conversion done route sits at bits 6..4 of offset 0x6F.
// - Clock lost halt route sits at bits 2..0 of offset 0x6F.
// - Program event one route sits at bits 6..4 of offset 0x70.
// - Program event two route sits at bits 2..0 of offset 0x70.
// - Program event three route sits at bits 6..4 of offset 0x71.
// - Program event four route sits at bits 2..0 of offset 0x71.
// - Bits 7 and 3 of each routing register are read/write, reset zero.
// - All routing fields reset to zero so nothing is routed after reset.
module isr_top
   import isr_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [ISR_ADDR_W-1:0] reg_addr_i,
   input wire logic [ISR_DATA_W-1:0] reg_wdata_i,
   output logic [ISR_DATA_W-1:0] reg_rdata_o,
   output logic reg_rvalid_o,
   input wire logic second_clock_fault_i,
   input wire logic conversion_done_i,
   input wire logic clock_lost_halt_i,
   input wire logic program_event_one_i,
   input wire logic program_event_two_i,
   input wire logic program_event_three_i,
   input wire logic program_event_four_i,
   output logic irq_out_one_o,
   output logic irq_out_two_o,
   output logic irq_out_three_o,
   output logic irq_out_four_o
);
   logic [ISR_DATA_W-1:0] second_clock_fault_reg;
   logic [ISR_DATA_W-1:0] conv_clk_reg;
   logic [ISR_DATA_W-1:0] prog_one_two_reg;
   logic [ISR_DATA_W-1:0] prog_three_four_reg;
   logic [ISR_ROUTE_W-1:0] route_sel [ISR_NUM_SRC];
   logic [ISR_NUM_SRC-1:0] src_vec;
   logic [ISR_NUM_OUT-1:0] req_vec [ISR_NUM_SRC];
   logic [ISR_NUM_OUT-1:0] irq_next;
   logic [ISR_NUM_OUT-1:0] irq_reg;
   logic [ISR_DATA_W-1:0] rdata_next;

   // Whole byte is stored, reserved bits included, so they read back
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         second_clock_fault_reg <= ISR_REG_RESET;
         conv_clk_reg <= ISR_REG_RESET;
         prog_one_two_reg <= ISR_REG_RESET;
         prog_three_four_reg <= ISR_REG_RESET;
      end
      else if (reg_wr_i)
      begin
         if (reg_addr_i == ISR_OFS_SECOND_CLOCK_FAULT)
            second_clock_fault_reg <= reg_wdata_i;
         if (reg_addr_i == ISR_OFS_CONV_DONE_CLK_LOST)
            conv_clk_reg <= reg_wdata_i;
         if (reg_addr_i == ISR_OFS_PROG_ONE_TWO)
            prog_one_two_reg <= reg_wdata_i;
         if (reg_addr_i == ISR_OFS_PROG_THREE_FOUR)
            prog_three_four_reg <= reg_wdata_i;
      end
   end

   // Read mux; unmapped offsets read as zero
   always_comb
   begin
      case (reg_addr_i)
         ISR_OFS_SECOND_CLOCK_FAULT: rdata_next = second_clock_fault_reg;
         ISR_OFS_CONV_DONE_CLK_LOST: rdata_next = conv_clk_reg;
         ISR_OFS_PROG_ONE_TWO: rdata_next = prog_one_two_reg;
         ISR_OFS_PROG_THREE_FOUR: rdata_next = prog_three_four_reg;
         default: rdata_next = '0;
      endcase
   end

   // Read data registered so the output comes straight from a flop
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         reg_rdata_o <= '0;
         reg_rvalid_o <= 1'b0;
      end
      else
      begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i)
            reg_rdata_o <= rdata_next;
      end
   end

   // Field extraction per source
   assign route_sel[0] = second_clock_fault_reg[ISR_LO_LSB +: ISR_ROUTE_W];
   assign route_sel[1] = conv_clk_reg[ISR_HI_LSB +: ISR_ROUTE_W];
   assign route_sel[2] = conv_clk_reg[ISR_LO_LSB +: ISR_ROUTE_W];
   assign route_sel[3] = prog_one_two_reg[ISR_HI_LSB +: ISR_ROUTE_W];
   assign route_sel[4] = prog_one_two_reg[ISR_LO_LSB +: ISR_ROUTE_W];
   assign route_sel[5] = prog_three_four_reg[ISR_HI_LSB +: ISR_ROUTE_W];
   assign route_sel[6] = prog_three_four_reg[ISR_LO_LSB +: ISR_ROUTE_W];
   assign src_vec = {program_event_four_i, program_event_three_i, program_event_two_i,
                     program_event_one_i, clock_lost_halt_i, conversion_done_i,
                     second_clock_fault_i};

   // One decoder per source
   generate
      for (genvar s = 0; s < ISR_NUM_SRC; s++)
      begin : g_src
         isr_route_decode u_dec (
            .route_i(route_sel[s]),
            .src_i(src_vec[s]),
            .req_o(req_vec[s])
         );
      end
   endgenerate

   // OR of all routed requests; reserved codes fall out as no request
   always_comb
   begin
      irq_next = '0;
      for (int s = 0; s < ISR_NUM_SRC; s++)
      begin
         irq_next = irq_next | req_vec[s];
      end
   end

   // Registered outputs cost one cycle of latency but keep pins glitch free
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         irq_reg <= '0;
      else
         irq_reg <= irq_next;
   end

   assign irq_out_one_o = irq_reg[0];
   assign irq_out_two_o = irq_reg[1];
   assign irq_out_three_o = irq_reg[2];
   assign irq_out_four_o = irq_reg[3];

   property p_code_zero_quiet;
      @(posedge clk_i) disable iff (sys_rst_i)
      (route_sel[1] == ISR_ROUTE_NONE && route_sel[0] == ISR_ROUTE_NONE && src_vec[6:2] == '0)
      |=> irq_reg == '0;
   endproperty
   a_code_zero_quiet: assert property (p_code_zero_quiet) else $error("unrouted sources drove an output");

   // Host keeps to codes 0 to 4; a stored reserved code would route nowhere and hide its event
   property p_reserved_code;
      @(posedge clk_i) disable iff (sys_rst_i)
      route_sel[0] <= ISR_ROUTE_LAST && route_sel[1] <= ISR_ROUTE_LAST && route_sel[2] <= ISR_ROUTE_LAST
         && route_sel[3] <= ISR_ROUTE_LAST && route_sel[4] <= ISR_ROUTE_LAST
         && route_sel[5] <= ISR_ROUTE_LAST && route_sel[6] <= ISR_ROUTE_LAST;
   endproperty
   a_reserved_code: assert property (p_reserved_code) else $error("reserved route code stored");

   property p_scf_route;
      @(posedge clk_i) disable iff (sys_rst_i)
      (second_clock_fault_i && second_clock_fault_reg[2:0] == 3'h2) |=> irq_out_two_o;
   endproperty
   a_scf_route: assert property (p_scf_route) else $error("second clock fault not routed to output two");

   property p_conv_route;
      @(posedge clk_i) disable iff (sys_rst_i)
      (conversion_done_i && conv_clk_reg[6:4] == 3'h3) |=> irq_out_three_o;
   endproperty
   a_conv_route: assert property (p_conv_route) else $error("conversion done not routed to output three");

   property p_lost_route;
      @(posedge clk_i) disable iff (sys_rst_i)
      (clock_lost_halt_i && conv_clk_reg[2:0] == 3'h4) |=> irq_out_four_o;
   endproperty
   a_lost_route: assert property (p_lost_route) else $error("clock lost not routed to output four");

   property p_prog_route;
      @(posedge clk_i) disable iff (sys_rst_i)
      (program_event_one_i && prog_one_two_reg[6:4] == 3'h1) |=> irq_out_one_o;
   endproperty
   a_prog_route: assert property (p_prog_route) else $error("program event one not routed to output one");

   property p_prog_two_route;
      @(posedge clk_i) disable iff (sys_rst_i)
      (program_event_two_i && prog_one_two_reg[2:0] == 3'h2) |=> irq_out_two_o;
   endproperty
   a_prog_two_route: assert property (p_prog_two_route) else $error("event two missed output two");

   property p_prog_three_route;
      @(posedge clk_i) disable iff (sys_rst_i)
      (program_event_three_i && prog_three_four_reg[6:4] == 3'h3) |=> irq_out_three_o;
   endproperty
   a_prog_three_route: assert property (p_prog_three_route) else $error("event three missed line three");

   property p_readback;
      @(posedge clk_i) disable iff (sys_rst_i)
      (reg_wr_i && reg_addr_i == ISR_OFS_PROG_THREE_FOUR) ##1 !reg_wr_i
         ##1 (reg_rd_i && !reg_wr_i && reg_addr_i == ISR_OFS_PROG_THREE_FOUR)
      |=> reg_rvalid_o && reg_rdata_o == $past(reg_wdata_i, 3);
   endproperty
   a_readback: assert property (p_readback) else $error("routing register did not read back its write");

   property p_reset_clear;
      @(posedge clk_i) sys_rst_i |=> (irq_reg == '0 && conv_clk_reg == ISR_REG_RESET && reg_rvalid_o == 1'b0);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("state not cleared by reset");

   property p_or_combine;
      @(posedge clk_i) disable iff (sys_rst_i)
      (program_event_four_i && prog_three_four_reg[2:0] == 3'h1 && !program_event_one_i) |=> irq_out_one_o;
   endproperty
   a_or_combine: assert property (p_or_combine) else $error("shared output missed a routed source");
endmodule
`default_nettype wire

/* File: isr_host_model.sv */
/*
 Host-side partner model: turns raw route bytes into bytes the host may write.
 Assumes the bench hands it whole register bytes before each write.
*/
`timescale 1ns/1ps
`default_nettype none
module isr_host_model
   import isr_pkg::*;
(
   input wire logic [7:0] raw_i,
   output logic [7:0] safe_o
);
   // Codes above 4 are reserved, so the host folds them to no route
   always_comb
   begin
      safe_o = raw_i;
      if (raw_i[6:4] > ISR_ROUTE_LAST) safe_o[6:4] = ISR_ROUTE_NONE;
      if (raw_i[2:0] > ISR_ROUTE_LAST) safe_o[2:0] = ISR_ROUTE_NONE;
   end
endmodule
`default_nettype wire

/* File: test_interrupt_source_routing.sv */
/*
 Self-checking bench for the routing matrix: register reset and readback,
 each source through each legal code, and random OR combinations.
 Assumes the one-cycle register port and one-cycle registered outputs.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
   $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module test_interrupt_source_routing
   import isr_pkg::*;
   ;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic [7:0] reg_rdata_o, raw, safe;
   logic reg_rvalid_o;
   logic [6:0] src = 7'h00;
   wire logic [3:0] irq;
   logic [7:0] mdl [0:3];
   int err_total = 0;
   int num_checks = 0;
   int cyc = 0;

   isr_host_model host (.raw_i(raw), .safe_o(safe));
   isr_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .reg_rvalid_o(reg_rvalid_o), .second_clock_fault_i(src[0]), .conversion_done_i(src[1]),
      .clock_lost_halt_i(src[2]), .program_event_one_i(src[3]), .program_event_two_i(src[4]),
      .program_event_three_i(src[5]), .program_event_four_i(src[6]), .irq_out_one_o(irq[0]),
      .irq_out_two_o(irq[1]), .irq_out_three_o(irq[2]), .irq_out_four_o(irq[3]));

   // Clock, 4 ns period
   initial
   begin
      forever #2 clk_i = ~clk_i;
   end

   // Expected lines: OR of every active source whose code is 1 to 4
   function automatic logic [3:0] exp_irq(input logic [6:0] s);
      logic [2:0] c;
      exp_irq = 4'h0;
      for (int i = 0; i < 7; i++)
      begin
         c = 3'(mdl[(i + 1) / 2] >> ((i % 2) * 4));
         if (s[i] && c >= ISR_ROUTE_FIRST && c <= ISR_ROUTE_LAST) exp_irq[c - 1] = 1'b1;
      end
   endfunction

   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Register r sits at the second clock fault offset plus r
   task automatic wr(input int r, input logic [7:0] d);
      raw = d;
      @(posedge clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= ISR_OFS_SECOND_CLOCK_FAULT + 8'(r);
      reg_wdata_i <= safe;
      mdl[r] = safe;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1;
      `CHK(reg_rvalid_o, 1'b1)
      `CHK(reg_rdata_o, e)
   endtask

   // Outputs lag the sources by one registered stage; two edges leave margin
   task automatic chk_src(input logic [6:0] s);
      @(posedge clk_i);
      src <= s;
      repeat (2) @(posedge clk_i);
      #1;
      `CHK(irq, exp_irq(s))
   endtask

   // Hang guard, far above the roughly 1200 cycles the run needs
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 8000)
      begin
         err_total++;
         test_done();
      end
   end

   initial
   begin
      void'($urandom(16539));
      for (int r = 0; r < 4; r++) mdl[r] = ISR_REG_RESET;
      repeat (6) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      for (int r = 0; r < 4; r++) rd(ISR_OFS_SECOND_CLOCK_FAULT + 8'(r), 8'h00);
      rd(8'h72, 8'h00);
      chk_src(7'h7F);
      // Write then read the same register with one idle cycle between, reserved bits set
      wr(3, 8'h9C);
      rd(ISR_OFS_PROG_THREE_FOUR, 8'h9C);
      wr(3, 8'h00);
      // Every source through every legal code, reserved bits set as well
      for (int i = 0; i < 7; i++)
         for (int c = 0; c < 5; c++)
         begin
            wr((i + 1) / 2, (8'(c) << ((i % 2) * 4)) | 8'h88);
            chk_src(7'(1 << i));
            rd(ISR_OFS_SECOND_CLOCK_FAULT + 8'((i + 1) / 2), mdl[(i + 1) / 2]);
         end
      // Random maps and sources, so lines are shared by several sources
      repeat (40)
      begin
         for (int r = 0; r < 4; r++) wr(r, 8'($urandom));
         for (int r = 0; r < 4; r++) rd(ISR_OFS_SECOND_CLOCK_FAULT + 8'(r), mdl[r]);
         chk_src(7'($urandom));
         chk_src(7'h7F);
      end
      // Reset in mid-run with routes programmed and every source still active
      @(posedge clk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      for (int r = 0; r < 4; r++) mdl[r] = ISR_REG_RESET;
      chk_src(7'h7F);
      for (int r = 0; r < 4; r++) rd(ISR_OFS_SECOND_CLOCK_FAULT + 8'(r), 8'h00);
      test_done();
   end
endmodule
`default_nettype wire
